// *** hdl/brk_cmp.sv ***
// Address break comparator: registers, match logic, break request.
// Assumes the CPU end presents one bus cycle per clock and lane data
// already placed by that end.
`timescale 1ns/1ps
`default_nettype none
module brk_cmp
(
   input  wire logic clk,
   input  wire logic rst_n,
   brk_if.dev        bus
);
   import brk_pkg::*;
   // ***************************************************
   // State and decoded fields
   // ***************************************************
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic        ien_r, ien_nxt;
   logic [15:0] baddr_r, baddr_nxt;
   logic [15:0] bdata_r, bdata_nxt;
   logic        flag_r, flag_nxt;
   logic        seen_r, seen_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic        req_r, req_nxt;
   logic        blk_r, blk_nxt;
   logic        match;
   logic [15:0] amask;
   logic        cyc_ok, dat_ok, lane_lo, addr_ok;
   logic [1:0]  cyc_sel, dat_sel;
   logic [2:0]  mask_sel;
   logic        wr_stat, rd_stat;

   // ***************************************************
   // Decoding helpers
   // ***************************************************
   // Mask select 1xx is reserved: only its low two bits steer
   function automatic logic [15:0] mask_of(input logic [2:0] sel);
      unique case (sel[1:0])
         2'h0: mask_of = 16'hFFFF;
         2'h1: mask_of = 16'hFFF0;
         2'h2: mask_of = 16'hFF00;
         2'h3: mask_of = 16'hF000;
      endcase
   endfunction

   // One register port strobe aimed at one index
   function automatic logic reg_hit(input logic       strobe,
                                    input logic [2:0] idx,
                                    input logic [2:0] want);
      reg_hit = strobe && idx == want;
   endfunction

   // ***************************************************
   // Match logic
   // ***************************************************
   always_comb
   begin
      cyc_sel  = ctrl_r[FLD_CYC +: 2];
      mask_sel = ctrl_r[FLD_AMASK +: 3];
      dat_sel  = ctrl_r[FLD_DSEL +: 2];
      amask    = mask_of(mask_sel);
      addr_ok  = (bus.addr & amask) == (baddr_r & amask);
      unique case (cyc_sel)
         CYC_FETCH: cyc_ok = bus.kind == BUS_FETCH;
         CYC_READ:  cyc_ok = bus.kind == BUS_READ;
         CYC_WRITE: cyc_ok = bus.kind == BUS_WRITE;
         CYC_RW:    cyc_ok = bus.kind == BUS_READ || bus.kind == BUS_WRITE;
      endcase
      // Odd word access to wide space uses lower lane; all else upper
      lane_lo = bus.word_acc
                && !bus.io8
                && bus.addr[0];
      unique case (dat_sel)
         DCMP_NONE: dat_ok = 1'b1;
         DCMP_LOW:
            dat_ok = lane_lo && bus.data[7:0] == bdata_r[7:0];
         DCMP_HIGH:
            dat_ok = !lane_lo && bus.data[15:8] == bdata_r[15:8];
         DCMP_WORD: dat_ok = bus.data == bdata_r;
      endcase
      match = addr_ok && cyc_ok && dat_ok;
   end

   // ***************************************************
   // Software registers
   // ***************************************************
   always_comb
   begin
      wr_stat = reg_hit(bus.reg_wr, bus.reg_addr, REG_STAT);
      rd_stat = reg_hit(bus.reg_rd, bus.reg_addr, REG_STAT);
   end

   always_comb
   begin
      ctrl_nxt  = ctrl_r;
      ien_nxt   = ien_r;
      baddr_nxt = baddr_r;
      bdata_nxt = bdata_r;
      if (bus.reg_wr)
      begin
         unique case (bus.reg_addr)
            REG_CTRL:   ctrl_nxt = bus.reg_wdata;
            REG_STAT:   ien_nxt  = bus.reg_wdata[BIT_IRQ_EN];
            REG_ADDR_H: baddr_nxt[15:8] = bus.reg_wdata;
            REG_ADDR_L: baddr_nxt[7:0]  = bus.reg_wdata;
            REG_DATA_H: bdata_nxt[15:8] = bus.reg_wdata;
            REG_DATA_L: bdata_nxt[7:0]  = bus.reg_wdata;
            default:    ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r  <= CTRL_RESET;
         ien_r   <= 1'b0;
         baddr_r <= ADDR_RESET;
      end
      else
      begin
         ctrl_r  <= ctrl_nxt;
         ien_r   <= ien_nxt;
         baddr_r <= baddr_nxt;
      end
   end

   // Data compare value is left unreset to save flops; software loads it
   always_ff @(posedge clk)
   begin
      bdata_r <= bdata_nxt;
   end

   // ***************************************************
   // Break flag and its read-before-clear arming
   // ***************************************************
   always_comb
   begin
      flag_nxt = flag_r;
      seen_nxt = seen_r;
      if (rd_stat && flag_r)
         seen_nxt = 1'b1;
      if (wr_stat && !bus.reg_wdata[BIT_FLAG] && seen_r)
      begin
         flag_nxt = 1'b0;
         seen_nxt = 1'b0;
      end
      // Set wins over clear, so a match in the clearing write is not lost
      if (match)
         flag_nxt = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_r <= 1'b0;
         seen_r <= 1'b0;
      end
      else
      begin
         flag_r <= flag_nxt;
         seen_r <= seen_nxt;
      end
   end

   // ***************************************************
   // Read data
   // ***************************************************
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (bus.reg_rd)
      begin
         unique case (bus.reg_addr)
            REG_CTRL:   rdata_nxt = ctrl_r;
            REG_STAT:   rdata_nxt = {flag_r, ien_r, STAT_RSVD};
            REG_ADDR_H: rdata_nxt = baddr_r[15:8];
            REG_ADDR_L: rdata_nxt = baddr_r[7:0];
            REG_DATA_H: rdata_nxt = bdata_r[15:8];
            REG_DATA_L: rdata_nxt = bdata_r[7:0];
            default:    rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end

   // ***************************************************
   // Break request
   // ***************************************************
   // Built from the next flag and enable, so it rises with the flag
   always_comb
   begin
      req_nxt = flag_nxt && ien_nxt;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         req_r <= 1'b0;
      else
         req_r <= req_nxt;
   end

   // ***************************************************
   // Interrupt block after a return
   // ***************************************************
   always_comb
   begin
      blk_nxt = blk_r;
      if (bus.insn_done)
         blk_nxt = 1'b0;
      // A return in the same cycle wins: its instruction is still ahead
      if (bus.rte_done && !ctrl_r[BIT_UNMASK])
         blk_nxt = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         blk_r <= 1'b0;
      else
         blk_r <= blk_nxt;
   end

   assign bus.reg_rdata = rdata_r;
   assign bus.break_req = req_r;
   assign bus.irq_block = blk_r;
endmodule
`default_nettype wire

// *** hdl/brk_cpu.sv ***
// CPU end: drives bus cycles and the register port from user requests.
// Assumes the user keeps its own requests legal.
`timescale 1ns/1ps
`default_nettype none
module brk_cpu
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire brk_pkg::bus_kind_type u_kind,
   input  wire logic [15:0]           u_addr,
   input  wire logic [15:0]           u_data,
   input  wire logic                  u_word,
   input  wire logic                  u_io8,
   input  wire logic                  u_rte,
   input  wire logic                  u_insn_done,
   input  wire logic                  u_reg_wr,
   input  wire logic                  u_reg_rd,
   input  wire logic [2:0]            u_reg_addr,
   input  wire logic [7:0]            u_reg_wdata,
   output logic [7:0]                 u_reg_rdata,
   output logic                       u_break,
   output logic                       u_block,
   brk_if.cpu                         bus
);
   import brk_pkg::*;
   logic [7:0] rd_r, rd_nxt;
   logic       brk_r, brk_nxt, blk_r, blk_nxt;

   // Lane placement: byte and 8-bit I/O data ride the upper lane in all but fetch cycles
   always_comb
   begin
      bus.data = u_data;
      if ((!u_word || u_io8) && u_kind != BUS_FETCH)
         bus.data = {u_data[7:0], 8'h00};
   end
   assign bus.kind      = u_kind;
   assign bus.addr      = u_addr;
   assign bus.word_acc  = u_word;
   assign bus.io8       = u_io8;
   assign bus.rte_done  = u_rte;
   assign bus.insn_done = u_insn_done;
   assign bus.reg_wr    = u_reg_wr;
   assign bus.reg_rd    = u_reg_rd;
   assign bus.reg_addr  = u_reg_addr;
   assign bus.reg_wdata = u_reg_wdata;

   always_comb
   begin
      rd_nxt  = bus.reg_rdata;
      brk_nxt = bus.break_req;
      blk_nxt = bus.irq_block;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_r  <= 8'h00;
         brk_r <= 1'b0;
         blk_r <= 1'b0;
      end
      else
      begin
         rd_r  <= rd_nxt;
         brk_r <= brk_nxt;
         blk_r <= blk_nxt;
      end
   end
   assign u_reg_rdata = rd_r;
   assign u_break     = brk_r;
   assign u_block     = blk_r;
endmodule
`default_nettype wire

// *** hdl/brk_if.sv ***
// Interface joining the CPU bus side and the address break comparator.
// Assumes both ends share clk.
`timescale 1ns/1ps
`default_nettype none
interface brk_if;
   import brk_pkg::*;
   bus_kind_type kind;
   logic [15:0]  addr;
   logic [15:0]  data;
   logic         word_acc;
   logic         io8;
   logic         rte_done;
   logic         insn_done;
   logic         reg_wr;
   logic         reg_rd;
   logic [2:0]   reg_addr;
   logic [7:0]   reg_wdata;
   logic [7:0]   reg_rdata;
   logic         break_req;
   logic         irq_block;
   modport dev (input kind, addr, data, word_acc, io8, rte_done, insn_done,
                input reg_wr, reg_rd, reg_addr, reg_wdata,
                output reg_rdata, break_req, irq_block);
   modport cpu (output kind, addr, data, word_acc, io8, rte_done, insn_done,
                output reg_wr, reg_rd, reg_addr, reg_wdata,
                input reg_rdata, break_req, irq_block);
endinterface
`default_nettype wire

// *** hdl/brk_pkg.sv ***
// Constants, register map and field layout of the address break comparator.
// Assumes one system clock and an 8-bit internal register port.
// Function
// - Bit 7 zero masks interrupts after return
// - Cycle select: fetch, read, write, either
// - Mask select: compare 16, 12, 8, 4 bits
// - Software never sets mask select top bit
// - Data select: none, low, high, full word
// - Word lane: even upper, odd lower
// - 8-bit I/O word: two upper-lane byte accesses
// - Byte accesses always use upper lane (CPU end leaves byte fetch data unplaced)
// - Satisfied conditions set break flag bit 7
// - Flag clears by zero write after read
// - Enable bit 6 gates break request
// - Status bits 5..0 read as ones
// - Break address 16 bits, resets all ones
// - Fetch break uses first instruction byte address
// - Data high vs upper lane, low vs lower
// - Byte data compare value in high byte
// - Break data register not reset
// - Request when flag and enable both set
// - Flag set even if other interrupt first
package brk_pkg;
   // ***************************************************
   // Register indices on the 8-bit port
   // ***************************************************
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_STAT   = 3'h1;
   localparam logic [2:0] REG_ADDR_H = 3'h2;
   localparam logic [2:0] REG_ADDR_L = 3'h3;
   localparam logic [2:0] REG_DATA_H = 3'h4;
   localparam logic [2:0] REG_DATA_L = 3'h5;
   // ***************************************************
   // Field positions and reset values
   // ***************************************************
   localparam int         BIT_UNMASK   = 7;
   localparam int         BIT_FLAG     = 7;
   localparam int         BIT_IRQ_EN   = 6;
   localparam int         FLD_CYC      = 5;
   localparam int         FLD_AMASK    = 2;
   localparam int         FLD_DSEL     = 0;
   localparam logic [7:0] CTRL_RESET   = 8'h80;
   localparam logic [5:0] STAT_RSVD    = 6'h3F;
   localparam logic [15:0] ADDR_RESET  = 16'hFFFF;
   // ***************************************************
   // Encodings
   // ***************************************************
   localparam logic [1:0] CYC_FETCH = 2'h0;
   localparam logic [1:0] CYC_READ  = 2'h1;
   localparam logic [1:0] CYC_WRITE = 2'h2;
   localparam logic [1:0] CYC_RW    = 2'h3;
   localparam logic [1:0] DCMP_NONE = 2'h0;
   localparam logic [1:0] DCMP_LOW  = 2'h1;
   localparam logic [1:0] DCMP_HIGH = 2'h2;
   localparam logic [1:0] DCMP_WORD = 2'h3;
   // Bus cycle kinds driven by the CPU side
   typedef enum logic [1:0]
   {
      BUS_IDLE  = 2'b00,
      BUS_FETCH = 2'b01,
      BUS_READ  = 2'b10,
      BUS_WRITE = 2'b11
   } bus_kind_type;
endpackage

// *** tb/brk_chk.sv ***
// Checker on the link between the CPU end and the break comparator.
// Assumes the bench feeds it the brk_if signals of the one link.
`timescale 1ns/1ps
`default_nettype none
module brk_chk
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire brk_pkg::bus_kind_type kind,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [2:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic [7:0]            reg_rdata,
   input  wire logic                  break_req,
   input  wire logic                  irq_block,
   input  wire logic                  rte_done,
   input  wire logic                  insn_done
);
   import brk_pkg::*;
   // ******
   // Properties
   // ******
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_rsvd_ones: assert property (
      reg_rd && reg_addr == REG_STAT |=> reg_rdata[5:0] == STAT_RSVD)
      else $error("reserved status bits not ones");
   // Idle cycle only: a match in the read cycle would move the request
   a_req_status: assert property (
      reg_rd && reg_addr == REG_STAT && kind == BUS_IDLE
      |=> break_req == (reg_rdata[7] & reg_rdata[6]))
      else $error("request differs from flag and enable");
   a_req_holds: assert property (
      break_req && !reg_wr |=> break_req)
      else $error("request dropped without a write");
   a_req_cause: assert property (
      !break_req && kind == BUS_IDLE && !reg_wr |=> !break_req)
      else $error("request rose without a cause");
   a_enable_off: assert property (
      reg_wr && reg_addr == REG_STAT && !reg_wdata[BIT_IRQ_EN]
      |=> !break_req)
      else $error("request with enable cleared");
   a_block_set: assert property (
      $rose(irq_block) |-> $past(rte_done))
      else $error("block without a return");
   a_block_clear: assert property (
      insn_done && !rte_done |=> !irq_block)
      else $error("block kept after an instruction");
   a_block_hold: assert property (
      irq_block && !insn_done |=> irq_block)
      else $error("block dropped early");
endmodule
`default_nettype wire

// *** tb/tb_brk_cmp.sv ***
// Bench: CPU end and break comparator joined by brk_if, driven from
// the user side. Assumes brk_pkg, brk_if and both ends compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_brk_cmp;
   import brk_pkg::*;
   // ******
   // Ends, stimulus and model state
   // ******
   logic         clk = '0, rst_n = '0;
   bus_kind_type u_kind = BUS_IDLE;
   logic [15:0]  u_addr = '0, u_data = '0, ba, bd;
   logic         u_word = '0, u_io8 = '0, u_rte = '0, u_insn_done = '0;
   logic         u_reg_wr = '0, u_reg_rd = '0, u_break, u_block;
   logic [2:0]   u_reg_addr = '0;
   logic [7:0]   u_reg_wdata = '0, u_reg_rdata, e;
   logic         r1 = '0, r2 = '0, flag = '0, en = '0, blk = '0;
   logic [31:0]  seed = 32'hBA225022;
   logic [9:0]   q[$];
   int           failures = 0, num_checks = 0, cycles = 0;
   // Lane cases: hit, data select, word, io8, odd address, data form
   logic [7:0]   lanes [10] = '{8'hB4, 8'h30, 8'hD0, 8'h54, 8'hC5, 8'h24,
                                8'hDD, 8'hF0, 8'h72, 8'h86};
   always #4 clk = ~clk;
   brk_if  brk_if_i ();
   brk_cmp brk_cmp_i (.clk, .rst_n, .bus(brk_if_i));
   brk_cpu brk_cpu_i (.clk, .rst_n, .u_kind, .u_addr, .u_data, .u_word,
      .u_io8, .u_rte, .u_insn_done, .u_reg_wr, .u_reg_rd, .u_reg_addr,
      .u_reg_wdata, .u_reg_rdata, .u_break, .u_block, .bus(brk_if_i));
   brk_chk brk_chk_i (.clk, .rst_n, .kind(brk_if_i.kind),
      .reg_wr(brk_if_i.reg_wr), .reg_rd(brk_if_i.reg_rd),
      .reg_addr(brk_if_i.reg_addr), .reg_wdata(brk_if_i.reg_wdata),
      .reg_rdata(brk_if_i.reg_rdata), .break_req(brk_if_i.break_req),
      .irq_block(brk_if_i.irq_block), .rte_done(brk_if_i.rte_done),
      .insn_done(brk_if_i.insn_done));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   task automatic close_out();
      if (failures == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      u_reg_wr <= 1'h1;
      u_reg_addr <= a;
      u_reg_wdata <= d;
      @(posedge clk);
      u_reg_wr <= 1'h0;
   endtask
   // Expectation noted now; block and request ride with the read data
   task automatic rd(input logic [2:0] a, input logic [7:0] d);
      q.push_back({blk, flag & en, d});
      @(posedge clk);
      u_reg_rd <= 1'h1;
      u_reg_addr <= a;
      @(posedge clk);
      u_reg_rd <= 1'h0;
   endtask
   task automatic cyc(input bus_kind_type k, input logic [15:0] a,
                      input logic [15:0] d, input logic w, input logic i,
                      input logic r, input logic n);
      @(posedge clk);
      u_kind <= k;
      u_addr <= a;
      u_data <= d;
      u_word <= w;
      u_io8 <= i;
      u_rte <= r;
      u_insn_done <= n;
      @(posedge clk);
      u_kind <= BUS_IDLE;
      u_rte <= 1'h0;
      u_insn_done <= 1'h0;
   endtask
   task automatic setup(input logic [7:0] ctl);
      seed = lfsr(seed);
      ba = seed[15:0];
      wr(REG_CTRL, ctl);
      wr(REG_ADDR_H, ba[15:8]);
      wr(REG_ADDR_L, ba[7:0]);
   endtask
   // Read arms the clear, so the following zero write empties the flag
   task automatic chkflag(input logic hit);
      flag = flag | hit;
      rd(REG_STAT, {flag, en, STAT_RSVD});
      wr(REG_STAT, {1'h0, en, 6'h00});
      flag = 1'h0;
   endtask
   // ******
   // Result watcher, timeout and main sequence
   // ******
   always @(posedge clk)
   begin
      r1 <= u_reg_rd;
      r2 <= r1;
      cycles++;
      if (r2)
         chk({u_block, u_break, u_reg_rdata}, q.pop_front());
      if (cycles == 3000)
      begin
         failures++;
         close_out();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      rd(REG_ADDR_H, 8'hFF);
      rd(REG_ADDR_L, 8'hFF);
      rd(REG_CTRL, CTRL_RESET);
      rd(REG_STAT, {2'h0, STAT_RSVD});
      wr(REG_STAT, 8'h40);
      en = 1'h1;
      for (int c = 0; c < 4; c++)
         for (int k = 1; k < 4; k++)
         begin
            setup({1'h1, c[1:0], 3'h0, DCMP_NONE});
            cyc(bus_kind_type'(k), ba, bd, 1'h1, 1'h0, 1'h0, 1'h0);
            chkflag((c == 0 && k == 1) || (c[0] && k == 2) ||
                    (c[1] && k == 3));
         end
      for (int m = 0; m < 4; m++)
      begin
         setup({1'h1, CYC_READ, m[2:0], DCMP_NONE});
         rd(REG_ADDR_L, ba[7:0]);
         cyc(BUS_READ, ba ^ ((16'h0001 << 4 * m) - 16'h0001), bd, 1'h1,
             1'h0, 1'h0, 1'h0);
         chkflag(1'h1);
         cyc(BUS_READ, ba ^ (16'h0001 << 4 * m), bd, 1'h1, 1'h0, 1'h0,
             1'h0);
         chkflag(1'h0);
      end
      seed = lfsr(seed);
      bd = seed[31:16];
      wr(REG_DATA_H, bd[15:8]);
      wr(REG_DATA_L, bd[7:0]);
      rd(REG_DATA_L, bd[7:0]);
      rd(REG_DATA_H, bd[15:8]);
      foreach (lanes[i])
      begin
         e = lanes[i];
         setup({1'h1, CYC_READ, 3'h1, e[6:5]});
         cyc(BUS_READ, {ba[15:1], e[2]}, e[1] ? bd ^ 16'h0001 : e[0] ?
             {bd[7:0], bd[15:8]} : bd, e[4], e[3], 1'h0, 1'h0);
         chkflag(e[7]);
      end
      setup({1'h1, CYC_WRITE, 3'h0, DCMP_NONE});
      cyc(BUS_WRITE, ba, bd, 1'h0, 1'h0, 1'h0, 1'h0);
      flag = 1'h1;
      wr(REG_STAT, 8'h00);
      en = 1'h0;
      rd(REG_STAT, {2'h2, STAT_RSVD});
      wr(REG_STAT, 8'h40);
      en = 1'h1;
      flag = 1'h0;
      rd(REG_STAT, {2'h1, STAT_RSVD});
      wr(REG_CTRL, 8'h00);
      cyc(BUS_IDLE, ba, bd, 1'h0, 1'h0, 1'h1, 1'h0);
      blk = 1'h1;
      rd(REG_CTRL, 8'h00);
      cyc(BUS_IDLE, ba, bd, 1'h0, 1'h0, 1'h0, 1'h1);
      blk = 1'h0;
      rd(REG_CTRL, 8'h00);
      wr(REG_CTRL, CTRL_RESET);
      cyc(BUS_IDLE, ba, bd, 1'h0, 1'h0, 1'h1, 1'h0);
      rd(REG_CTRL, CTRL_RESET);
      // Second reset once the last read has been compared
      repeat (4) @(posedge clk);
      rst_n <= 1'h0;
      en = 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      rd(REG_ADDR_H, 8'hFF);
      rd(REG_ADDR_L, 8'hFF);
      rd(REG_STAT, {2'h0, STAT_RSVD});
      repeat (4) @(posedge clk);
      if (q.size() != 0)
         failures++;
      close_out();
   end
endmodule
`default_nettype wire
